// >>> comc_defs.vh
// constants for the clock output mode control block
`ifndef COMC_DEFS_VH
`define COMC_DEFS_VH
`define COMC_NOUT 10
`define COMC_NDIV 8
// driver type select codes
`define COMC_DRV_PECL 2'h0
`define COMC_DRV_LVDS 2'h1
`define COMC_DRV_CMOS 2'h2
`define COMC_DRV_OFF 2'h3
// per-side cmos state (spi mode)
`define COMC_CM_ACT 2'h0
`define COMC_CM_INV 2'h1
`define COMC_CM_LOW 2'h2
`define COMC_CM_HIZ 2'h3
// bits 22..25 of each output register, as a 4-bit field
`define COMC_CMOS_P_LSB 0
`define COMC_CMOS_N_LSB 2
`define COMC_CMOS_SEL_P 0
`define COMC_CMOS_SEL_N 1
// operating modes
`define COMC_MODE_NORMAL 3'h0
`define COMC_MODE_PDOWN 3'h1
`define COMC_MODE_SLEEP 3'h2
`define COMC_MODE_RESET 3'h3
`define COMC_MODE_HOLD 3'h4
// divider sync pulse length in source clock cycles
`define COMC_SYNC_LEN 4'h4
`define COMC_SYNC_CNT_W 4
`endif

// >>> comc_out_buf.v
// driver enables for one universal output buffer
`timescale 1ns/1ps
`include "comc_defs.vh"
module comc_out_buf (
	input wire ref_clk, // system clock
	input wire srst, // sync reset, active high
	input wire [1:0] drv_sel, // driver type select
	input wire [3:0] cmos_cfg, // cmos control field
	input wire pin_cfg_mode, // pin-configured mode
	input wire outs_off, // force all drivers off
	input wire clk_in, // divided clock
	output reg pecl_en_q, // pecl driver enable
	output reg lvds_en_q, // lvds driver enable
	output reg [1:0] cmos_en_q, // cmos enables {n,p}
	output reg [1:0] cmos_dat_q, // cmos data {n,p}
	output reg low_pwr_q // unused drivers in low power
);
	reg [1:0] cm_en;
	reg [1:0] cm_dat;
	reg [1:0] st;
	integer i;
	always @*
	begin
		cm_en = 2'h0;
		cm_dat = 2'h0;
		for (i = 0; i < 2; i = i + 1)
		begin
			st = cmos_cfg[2*i +: 2];
			if (pin_cfg_mode)
			begin
				cm_en[i] = cmos_cfg[i];
				cm_dat[i] = clk_in;
			end
			else
			begin
				case (st)
				`COMC_CM_ACT:
				begin
					cm_en[i] = 1'b1;
					cm_dat[i] = clk_in;
				end
				`COMC_CM_INV:
				begin
					cm_en[i] = 1'b1;
					cm_dat[i] = ~clk_in;
				end
				`COMC_CM_LOW:
				begin
					cm_en[i] = 1'b1;
					cm_dat[i] = 1'b0;
				end
				default:
				begin
					cm_en[i] = 1'b0;
					cm_dat[i] = 1'b0;
				end
				endcase
			end
		end
	end
	always @(posedge ref_clk)
	begin
		if (srst || outs_off)
		begin
			pecl_en_q <= 1'b0;
			lvds_en_q <= 1'b0;
			cmos_en_q <= 2'h0;
			cmos_dat_q <= 2'h0;
			low_pwr_q <= 1'b1;
		end
		else
		begin
			// at most one driver type on, by construction of the decode
			pecl_en_q <= (drv_sel == `COMC_DRV_PECL);
			lvds_en_q <= (drv_sel == `COMC_DRV_LVDS);
			cmos_en_q <= (drv_sel == `COMC_DRV_CMOS) ? cm_en : 2'h0;
			cmos_dat_q <= cm_dat;
			low_pwr_q <= 1'b1; // idle drivers always low power
		end
	end
endmodule // comc_out_buf

// >>> comc_sync_gen.v
// divider synchronisation pulse generator
`timescale 1ns/1ps
`include "comc_defs.vh"
module comc_sync_gen (
	input wire ref_clk, // system clock
	input wire srst, // sync reset
	input wire src_en, // source clock edge enable
	input wire sync_req, // request a divider sync
	output reg div_rst_q // common divider reset
);
	reg [`COMC_SYNC_CNT_W-1:0] cnt_q;
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			cnt_q <= {`COMC_SYNC_CNT_W{1'b0}};
			div_rst_q <= 1'b0;
		end
		else if (sync_req)
		begin
			cnt_q <= `COMC_SYNC_LEN;
			div_rst_q <= 1'b1;
		end
		else if (src_en && div_rst_q)
		begin
			// release only on a source edge so all dividers leave together
			cnt_q <= cnt_q - 1'b1;
			if (cnt_q == {{(`COMC_SYNC_CNT_W-1){1'b0}}, 1'b1})
				div_rst_q <= 1'b0;
		end
	end
endmodule // comc_sync_gen

// >>> comc_top.v
// clock output mode control: driver select, divider sync, power modes
`timescale 1ns/1ps
`include "comc_defs.vh"
module comc_top (
	input wire ref_clk, // 100 MHz system clock
	input wire srst, // sync reset, active high
	input wire powerdown_n_pin, // power-down pin, active low
	input wire sleep_n, // sleep bit, active low
	input wire reset_hold_sel, // stored bit: 0 reset, 1 hold
	input wire reset_hold_bit, // register reset/hold control
	input wire reset_hold_n_pin, // reset/hold pin
	input wire pin_configured_mode, // pin-configured mode
	input wire [19:0] drv_sel, // 2-bit driver type per output
	input wire [39:0] cmos_cfg, // 4-bit cmos field per output
	input wire [9:0] clk_div, // divided clock per output
	input wire sync_src_en, // sync source clock edge enable
	input wire sync_req, // divider sync request
	output reg [9:0] pecl_en_q, // pecl enables
	output reg [9:0] lvds_en_q, // lvds enables
	output reg [19:0] cmos_en_q, // cmos enables {n,p} per output
	output reg [19:0] cmos_dat_q, // cmos data {n,p} per output
	output reg [9:0] low_pwr_q, // idle drivers low power
	output reg [7:0] div_rst_q, // divider resets
	output reg charge_pump_out_oe_q, // charge pump drive enable
	output reg nv_reload_q, // reload defaults pulse
	output reg [2:0] mode_q // current mode
);
	////////////////////////////////////////////////////////////////
	function [2:0] dec_mode;
		input pwr_n;
		input sl_n;
		input sel;
		input bit_r;
		input pin_r;
		begin
			if (!pwr_n)
				dec_mode = `COMC_MODE_PDOWN;
			else if (!sl_n)
				dec_mode = `COMC_MODE_SLEEP;
			else if (!(bit_r && pin_r))
				// one path, stored bit picks the function
				dec_mode = sel ? `COMC_MODE_HOLD : `COMC_MODE_RESET;
			else
				dec_mode = `COMC_MODE_NORMAL;
		end
	endfunction
	////////////////////////////////////////////////////////////////
	wire [2:0] mode_d;
	wire outs_off;
	wire div_rst;
	wire [9:0] b_pecl;
	wire [9:0] b_lvds;
	wire [19:0] b_cen;
	wire [19:0] b_cdat;
	wire [9:0] b_lp;
	assign mode_d = dec_mode(powerdown_n_pin, sleep_n, reset_hold_sel,
		reset_hold_bit, reset_hold_n_pin);
	// hold keeps clocks running; only reset/sleep/power-down stop them
	assign outs_off = (mode_q == `COMC_MODE_PDOWN) ||
		(mode_q == `COMC_MODE_SLEEP) || (mode_q == `COMC_MODE_RESET);
	always @(posedge ref_clk)
	begin
		if (srst)
		begin
			mode_q <= `COMC_MODE_PDOWN;
			nv_reload_q <= 1'b0;
			charge_pump_out_oe_q <= 1'b0;
		end
		else
		begin
			mode_q <= mode_d;
			// sleep exit keeps registers, so no reload
			nv_reload_q <= (mode_q == `COMC_MODE_PDOWN) &&
				(mode_d != `COMC_MODE_PDOWN);
			charge_pump_out_oe_q <= (mode_d == `COMC_MODE_NORMAL);
		end
	end
	////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < `COMC_NOUT; g = g + 1)
		begin : g_buf
			comc_out_buf u_buf (
				.ref_clk(ref_clk),
				.srst(srst),
				.drv_sel(drv_sel[2*g +: 2]),
				.cmos_cfg(cmos_cfg[4*g +: 4]),
				.pin_cfg_mode(pin_configured_mode),
				.outs_off(outs_off),
				.clk_in(clk_div[g]),
				.pecl_en_q(b_pecl[g]),
				.lvds_en_q(b_lvds[g]),
				.cmos_en_q(b_cen[2*g +: 2]),
				.cmos_dat_q(b_cdat[2*g +: 2]),
				.low_pwr_q(b_lp[g])
			);
		end
	endgenerate
	always @*
	begin
		pecl_en_q = b_pecl;
		lvds_en_q = b_lvds;
		cmos_en_q = b_cen;
		cmos_dat_q = b_cdat;
		low_pwr_q = b_lp;
		div_rst_q = {`COMC_NDIV{div_rst}};
	end
	////////////////////////////////////////////////////////////////
	comc_sync_gen u_sync (
		.ref_clk(ref_clk),
		.srst(srst),
		.src_en(sync_src_en),
		.sync_req(sync_req),
		.div_rst_q(div_rst)
	);
endmodule // comc_top

// >>> comc_clk_loads.sv
// stand-in for the clock loads and the divider sync source
`timescale 1ns/1ps
module comc_clk_loads (
	input wire ref_clk, // system clock
	output logic [9:0] clk_div, // divided clocks
	output logic sync_src_en // source edge enable
);
	logic [2:0] cnt_q = 3'h0;
	initial {clk_div, sync_src_en} = 11'h000;
	// one enable in five: a 20 MHz source, well inside the legal band
	always @(posedge ref_clk)
	begin
		cnt_q <= (cnt_q == 3'h4) ? 3'h0 : cnt_q + 3'h1;
		sync_src_en <= (cnt_q == 3'h4);
		clk_div <= ~clk_div;
	end
endmodule // comc_clk_loads

// >>> comc_top_asserts.sv
// port assertions for the clock output mode control
`timescale 1ns/1ps
module comc_top_asserts (
	input wire ref_clk, // clock
	input wire srst, // reset
	input wire powerdown_n_pin, // power-down pin
	input wire sleep_n, // sleep
	input wire reset_hold_sel, // select
	input wire reset_hold_bit, // ctl bit
	input wire reset_hold_n_pin, // ctl pin
	input wire sync_src_en, // src edge
	input wire sync_req, // sync req
	input wire [9:0] pecl_en_q, // pecl
	input wire [9:0] lvds_en_q, // lvds
	input wire [19:0] cmos_en_q, // cmos
	input wire [7:0] div_rst_q, // div resets
	input wire charge_pump_out_oe_q, // pump drive enable
	input wire nv_reload_q, // reload
	input wire [2:0] mode_q // mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	wire act = powerdown_n_pin && sleep_n;
	wire pair = reset_hold_bit && reset_hold_n_pin;
	wire [9:0] cm_any;
	genvar g;
	generate
		for (g = 0; g < 10; g = g + 1)
		begin : g_any
			assign cm_any[g] = |cmos_en_q[2*g +: 2];
		end
	endgenerate
	sequence drv_off;
		pecl_en_q == 10'h000 && lvds_en_q == 10'h000 && cmos_en_q == 20'h0_0000;
	endsequence
	one_type_a: assert property (!(pecl_en_q & lvds_en_q))
		else $error("two driver types on");
	cmos_excl_a: assert property (((pecl_en_q | lvds_en_q) & cm_any) == 10'h000)
		else $error("cmos on with another type");
	sleep_keep_a: assert property (mode_q == 3'h2 |=> !nv_reload_q)
		else $error("reload after sleep");
	pdown_mode_a: assert property (!powerdown_n_pin |=> mode_q == 3'h1)
		else $error("power-down not entered");
	wake_reload_a: assert property ($rose(powerdown_n_pin) |=> nv_reload_q)
		else $error("no reload on wake");
	sleep_mode_a: assert property (powerdown_n_pin && !sleep_n |=> mode_q == 3'h2)
		else $error("sleep not entered");
	reset_mode_a: assert property (act && !reset_hold_sel && !pair |=> mode_q == 3'h3)
		else $error("reset not entered");
	hold_mode_a: assert property (act && reset_hold_sel && !pair |=>
		mode_q == 3'h4 && !charge_pump_out_oe_q) else $error("hold wrong");
	normal_mode_a: assert property (act && pair |=> mode_q == 3'h0)
		else $error("normal not entered");
	off_drv_a: assert property (mode_q inside {3'h1, 3'h2, 3'h3} && !$past(srst)
		|=> drv_off) else $error("drivers on while off");
	sync_go_a: assert property (sync_req |=> div_rst_q == 8'hff)
		else $error("sync pulse missing");
	sync_same_a: assert property (div_rst_q == 8'h00 || div_rst_q == 8'hff)
		else $error("dividers reset apart");
	sync_rel_a: assert property ($fell(div_rst_q[0]) |-> $past(sync_src_en))
		else $error("release off source edge");
endmodule // comc_top_asserts
bind comc_top comc_top_asserts u_chk (.*);

// >>> testbench.sv
// self-checking bench for the clock output mode control
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0, srst = 1'b1, pwr_n = 1'b1, sl_n = 1'b1, sel = 1'b0;
	logic rh_bit = 1'b1, rh_pin = 1'b1, pcm = 1'b0, sreq = 1'b0, src_en;
	logic [19:0] drv = 20'h0_0000, cm_en, cm_dat;
	logic [39:0] cfg = 40'h00_0000_0000;
	logic [9:0] cdiv, pe, le, lp;
	logic [7:0] drst;
	logic pump_oe, rel;
	logic [2:0] md;
	int n_mismatch = 0, checks_done = 0, k, n;
	always #5 ref_clk = ~ref_clk;
	comc_clk_loads u_ld (.ref_clk(ref_clk), .clk_div(cdiv), .sync_src_en(src_en));
	comc_top uut (.ref_clk(ref_clk), .srst(srst), .powerdown_n_pin(pwr_n),
		.sleep_n(sl_n), .reset_hold_sel(sel), .reset_hold_bit(rh_bit),
		.reset_hold_n_pin(rh_pin), .pin_configured_mode(pcm), .drv_sel(drv),
		.cmos_cfg(cfg), .clk_div(cdiv), .sync_src_en(src_en), .sync_req(sreq),
		.pecl_en_q(pe), .lvds_en_q(le), .cmos_en_q(cm_en), .cmos_dat_q(cm_dat),
		.low_pwr_q(lp), .div_rst_q(drst), .charge_pump_out_oe_q(pump_oe),
		.nv_reload_q(rel), .mode_q(md));
	////////////////////////////////////////////////////////////////////
	function logic [2:0] exp_mode(input logic [4:0] v);
		if (!v[4]) return 3'h1;
		if (!v[3]) return 3'h2;
		if (v[1:0] == 2'h3) return 3'h0;
		return v[2] ? 3'h4 : 3'h3;
	endfunction
	function logic [1:0] exp_cm(input logic [1:0] d, input logic [3:0] c,
		input logic p);
		if (d != 2'h2) return 2'h0;
		if (p) return c[1:0];
		return {c[3:2] != 2'h3, c[1:0] != 2'h3};
	endfunction
	// ck is the divided clock as the buffer sampled it
	function logic [1:0] exp_dat(input logic [3:0] c, input logic p,
		input logic ck);
		logic [1:0] r;
		for (int s = 0; s < 2; s++)
			case (p ? 2'h0 : c[2*s+:2])
			2'h0: r[s] = ck;
			2'h1: r[s] = ~ck;
			default: r[s] = 1'b0;
			endcase
		return r;
	endfunction
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		k = $urandom(32'hd5a7);
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		for (k = 0; k < 32; k++)
		begin
			@(posedge ref_clk);
			{pwr_n, sl_n, sel, rh_bit, rh_pin} <= k[4:0];
			drv <= 20'($urandom);
			repeat (3) @(posedge ref_clk);
			#1 chk(md, exp_mode(k[4:0]));
			if (exp_mode(k[4:0]) inside {3'h1, 3'h2, 3'h3})
				chk({pe, le, cm_en}, 40'h00_0000_0000);
			if (exp_mode(k[4:0]) == 3'h4) chk(pump_oe, 1'b0);
		end
		@(posedge ref_clk) pwr_n <= 1'b0;
		@(posedge ref_clk) pwr_n <= 1'b1;
		@(posedge ref_clk) #1 chk(rel, 1'b1);
		@(posedge ref_clk) #1 chk(rel, 1'b0);
		// even passes in hold: drivers must stay up there
		for (k = 0; k < 44; k++)
		begin
			@(posedge ref_clk);
			drv <= (k < 4) ? {10{k[1:0]}} : 20'($urandom);
			cfg <= {$urandom, 8'($urandom)};
			pcm <= k[1];
			rh_pin <= k[0];
			repeat (3) @(posedge ref_clk);
			#1 chk(pump_oe, k[0]);
			chk(lp, 10'h3ff);
			for (n = 0; n < 10; n++)
			begin
				chk(pe[n], drv[2*n+:2] == 2'h0);
				chk(le[n], drv[2*n+:2] == 2'h1);
				chk(cm_en[2*n+:2], exp_cm(drv[2*n+:2], cfg[4*n+:4], pcm));
				chk(cm_dat[2*n+:2], exp_dat(cfg[4*n+:4], pcm, ~cdiv[n]));
			end
		end
		@(posedge ref_clk) sreq <= 1'b1;
		@(posedge ref_clk) sreq <= 1'b0;
		#1 chk(drst, 8'hff);
		n = 0;
		repeat (60)
		begin
			if (drst === 8'hff && src_en === 1'b1) n++;
			@(posedge ref_clk) #1;
		end
		chk(40'(n), 40'h00_0000_0004);
		chk(drst, 8'h00);
		tally_and_finish;
	end
	initial
	begin
		#20000;
		n_mismatch++;
		tally_and_finish;
	end
endmodule // testbench
